// ===== bench/serr_regs_chk.sv
/*
  Concurrent checks on the ports of the lane diagnostic register bank.
  Assumes it is bound to serr_regs and that the master follows classic Wishbone.
*/
`default_nettype none

module serr_regs_chk
  import serr_pkg::*;
#(
  parameter int ADR_W = 12
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [3:0]       signal_loss_threshold_o,
  input wire logic [8:0]       equalizer_votes_o,
  input wire logic             recovery_freeze_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic [9:0] idx = wb_adr_i[11:2];
  wire logic       rd  = wb_ack_o && !wb_we_i;
  wire logic       wr  = wb_ack_o && wb_we_i && wb_sel_i[0];

  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  freeze_tracks_a: assert property (wr && idx == IDX_FREEZE |=> recovery_freeze_o == $past(wb_dat_i[0]))
    else $error("freeze output does not follow write");
  thr_tracks_a: assert property (wr && idx == IDX_LOSS_THRESHOLD |=>
    signal_loss_threshold_o == $past(wb_dat_i[3:0])) else $error("threshold output does not follow write");
  votes_legal_a: assert property (equalizer_votes_o inside {9'h1ff, 9'h1, 9'h3, 9'h7, 9'hf, 9'h1f, 9'h3f,
    9'h7f, 9'hff}) else $error("vote count outside encoding");
  unwired_zero_a: assert property (rd && idx[9:5] == 5'h10 && idx[3:0] != WIRED_LANE_A
    && idx[3:0] != WIRED_LANE_B |-> wb_dat_o == 32'h0) else $error("unwired lane reads nonzero");
  volt_width_a: assert property (rd && idx[9:4] == 6'h20 |-> wb_dat_o[31:6] == 26'h0)
    else $error("voltage result wider than six bits");
  vector_wired_a: assert property (rd && idx == IDX_SCAN_COMPLETE |-> (wb_dat_o & ~32'h4040) == 32'h0)
    else $error("completion bit set for unwired lane");
endmodule : serr_regs_chk

bind serr_regs serr_regs_chk #(.ADR_W(ADR_W)) u_serr_regs_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .signal_loss_threshold_o(signal_loss_threshold_o),
  .equalizer_votes_o(equalizer_votes_o), .recovery_freeze_o(recovery_freeze_o));

`default_nettype wire

// ===== bench/test_serr_regs.sv
/*
  Self-checking bench for the lane diagnostic register bank.
  Assumes serr_pkg and serr_regs are compiled first; the bench drives lanes itself.
*/
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module test_serr_regs
  import serr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h0;
  logic [3:0]  wb_sel = 4'h0, scan_mode_select_o, signal_loss_threshold_o;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
  logic [1:0]  valid = 2'h0, norm = 2'h0, offs = 2'h1, done = 2'h0;
  logic [5:0]  volt_a = 6'h2a, volt_b = 6'h15;
  logic [7:0]  ph_a = 8'h35, ph_b = 8'h5a;
  logic [8:0]  equalizer_votes_o;
  logic        wb_ack_o, signal_loss_detect_enable_o, recovery_freeze_o, irq_o, irq_a;
  int          fail_count = 0, samples_checked = 0, cycles = 0;

  always #2 clk_i = ~clk_i;

  serr_regs u_serr_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lane_sample_valid_i(valid), .lane_normal_bit_i(norm), .lane_offset_bit_i(offs), .lane_scan_done_i(done),
    .lane_voltage_a_i(volt_a), .lane_voltage_b_i(volt_b), .lane_phase_a_i(ph_a), .lane_phase_b_i(ph_b),
    .scan_mode_select_o(scan_mode_select_o), .signal_loss_threshold_o(signal_loss_threshold_o),
    .signal_loss_detect_enable_o(signal_loss_detect_enable_o), .equalizer_votes_o(equalizer_votes_o),
    .recovery_freeze_o(recovery_freeze_o), .irq_o(irq_o));

  // ---------------------------------------------------------------------------
  // Bus and lane tasks.
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= {i, 2'h0};
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    xfer(1'b1, i, d, 4'hf, q);
  endtask : wr

  task automatic rd_chk(input logic [9:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0, 4'hf, q);
    `CHK(q, e)
  endtask : rd_chk

  // Mismatches on lane 6 only, one per cycle for n cycles.
  task automatic hits(input int n);
    @(posedge clk_i);
    valid <= 2'h3;
    repeat (n) @(posedge clk_i);
    valid <= 2'h0;
  endtask : hits

  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  // ---------------------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDX_LOSS_THRESHOLD, 32'h8);
    rd_chk(IDX_VOTE_SIZE, 32'h0);
    rd_chk(IDX_FREEZE, 32'h0);
    rd_chk(IDX_ERR_CLEAR, 32'h0);
    `CHK(equalizer_votes_o, VOTES_DEFAULT)
    `CHK(recovery_freeze_o, 1'b0)
    rd_chk(10'h3ff, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_VOTE_SIZE, 32'(c));
      rd_chk(IDX_VOTE_SIZE, 32'(c));
      `CHK(equalizer_votes_o, (c >= 2 && c <= 9) ? 9'((1 << (c - 1)) - 1) : VOTES_DEFAULT)
    end
    wr(IDX_VOTE_SIZE, 32'h0);
    `CHK(equalizer_votes_o, VOTES_DEFAULT)
    wr(IDX_LOSS_THRESHOLD, 32'hf);
    xfer(1'b1, IDX_LOSS_THRESHOLD, 32'h3, 4'he, q);
    rd_chk(IDX_LOSS_THRESHOLD, 32'hf);
    `CHK(signal_loss_threshold_o, 4'hf)
    wr(IDX_SCAN_CONTROL, 32'h11);
    hits(5);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h5);
    rd_chk(IDX_MISMATCH_BASE + 10'he, 32'h0);
    `CHK(scan_mode_select_o, MODE_COMPARE)
    `CHK(signal_loss_detect_enable_o, 1'b1)
    wr(IDX_ERR_CLEAR, 32'h1);
    hits(3);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h0);
    wr(IDX_ERR_CLEAR, 32'h0);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h0);
    hits(2);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h2);
    wr(IDX_SCAN_CONTROL, 32'h3);
    hits(2);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h2);
    wr(IDX_SCAN_CONTROL, 32'h4);
    hits(1);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h3);
    wr(IDX_SCAN_CONTROL, 32'h2);
    hits(1);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h4);
    rd_chk(IDX_MISMATCH_BASE + 10'he, 32'h0);
    wr(IDX_SCAN_CONTROL, 32'h8);
    wr(IDX_IRQ_MASK, 32'h0);
    done <= 2'h1;
    rd_chk(IDX_SCAN_COMPLETE, 32'h40);
    rd_chk(IDX_VOLTAGE_BASE + 10'h6, 32'h2a);
    irq_a = irq_o;
    wr(IDX_IRQ_MASK, 32'hf);
    rd_chk(IDX_VOLTAGE_BASE, 32'h0);
    `CHK(irq_a, 1'b0)
    `CHK(irq_o, 1'b1)
    rd_chk(IDX_IRQ_STATUS, 32'h1);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    `CHK(irq_o, 1'b0)
    done <= 2'h3;
    rd_chk(IDX_SCAN_COMPLETE, 32'h4040);
    rd_chk(IDX_VOLTAGE_BASE + 10'he, 32'h15);
    wr(IDX_SCAN_COMPLETE, 32'hffff);
    rd_chk(IDX_SCAN_COMPLETE, 32'h4040);
    rd_chk(IDX_IRQ_STATUS, 32'h2);
    wr(IDX_SCAN_CONTROL, 32'h1);
    hits(2);
    rd_chk(IDX_MISMATCH_BASE + 10'h6, 32'h4);
    wr(IDX_LANE_SELECT, 32'h6);
    wr(IDX_FREEZE, 32'h1);
    ph_a <= 8'hc3;
    rd_chk(IDX_PHASE, 32'h35);
    `CHK(recovery_freeze_o, 1'b1)
    wr(IDX_FREEZE, 32'h0);
    rd_chk(IDX_PHASE, 32'hc3);
    wr(IDX_LANE_SELECT, 32'he);
    rd_chk(IDX_PHASE, 32'h5a);
    wr(IDX_LANE_SELECT, 32'h0);
    rd_chk(IDX_PHASE, 32'h0);
    tally_and_finish;
  end
endmodule : test_serr_regs

`undef CHK
`default_nettype wire

// ===== logic/serr_pkg.sv
/*
  Constants for the receive-lane diagnostic register bank: register indices,
  field positions, reset values and encodings.
  Assumes a 32-bit classic Wishbone bus whose byte address is four times the index.
*/
`default_nettype none

package serr_pkg;

  // ---------------------------------------------------------------------------
  // Register indices; byte address is index times four.
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_ERR_CLEAR      = 10'h1f5;
  localparam logic [9:0] IDX_SCAN_COMPLETE  = 10'h1f6;
  localparam logic [9:0] IDX_VOLTAGE_BASE   = 10'h200;
  localparam logic [9:0] IDX_MISMATCH_BASE  = 10'h210;
  localparam logic [9:0] IDX_LOSS_THRESHOLD = 10'h234;
  localparam logic [9:0] IDX_VOTE_SIZE      = 10'h235;
  localparam logic [9:0] IDX_FREEZE         = 10'h238;
  localparam logic [9:0] IDX_PHASE          = 10'h239;
  localparam logic [9:0] IDX_LANE_SELECT    = 10'h23a;
  localparam logic [9:0] IDX_SCAN_CONTROL   = 10'h23b;
  localparam logic [9:0] IDX_IRQ_STATUS     = 10'h23c;
  localparam logic [9:0] IDX_IRQ_MASK       = 10'h23d;

  // ---------------------------------------------------------------------------
  // Reset values and field positions.
  // ---------------------------------------------------------------------------
  localparam logic [0:0] RST_ERR_CLEAR      = 1'h0;
  localparam logic [3:0] RST_LOSS_THRESHOLD = 4'h8;
  localparam logic [3:0] RST_VOTE_SIZE      = 4'h0;
  localparam logic [0:0] RST_FREEZE         = 1'h0;
  localparam logic [3:0] RST_LANE_SELECT    = 4'h0;
  localparam logic [3:0] RST_SCAN_MODE      = 4'h0;
  localparam int         POS_LOSS_ENABLE    = 4;

  // ---------------------------------------------------------------------------
  // Lane map and scan-mode encodings.
  // ---------------------------------------------------------------------------
  localparam int         NUM_LANES          = 16;
  localparam int         NUM_WIRED          = 2;
  localparam logic [3:0] WIRED_LANE_A       = 4'h6;
  localparam logic [3:0] WIRED_LANE_B       = 4'he;
  localparam logic [3:0] MODE_COMPARE       = 4'h1;
  localparam logic [3:0] MODE_COMPARE_ZEROS = 4'h2;
  localparam logic [3:0] MODE_COMPARE_ONES  = 4'h3;
  localparam logic [3:0] MODE_COUNT_ONES    = 4'h4;
  localparam logic [8:0] VOTES_DEFAULT      = 9'h1ff;
  localparam logic [3:0] VOTE_CODE_MIN      = 4'h2;
  localparam logic [3:0] VOTE_CODE_MAX      = 4'h9;
  localparam logic [15:0] COUNT_MAX         = 16'hffff;

  // Interrupt status bit layout: done for lane A, B, then saturation for A, B.
  localparam int         IRQ_W              = 4;

endpackage : serr_pkg

`default_nettype wire

// ===== logic/serr_regs.sv
/*
  Receive-lane diagnostic register bank: error/mismatch counters, scan-complete
  vector, per-lane voltage results, loss-of-signal threshold, equalizer vote
  size, recovery freeze and phase readback, with a read-clear interrupt.
  Assumes a classic Wishbone master, lane signals synchronous to clk_i, and
  that only physical lanes 6 and 14 are wired; index 0 of lane ports is lane 6.
*/
// The Wishbone interface to the registers is this design's own decision.
`default_nettype none

module serr_regs
  import serr_pkg::*;
#(
  parameter int ADR_W = 12
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [NUM_WIRED-1:0] lane_sample_valid_i,
  input  wire logic [NUM_WIRED-1:0] lane_normal_bit_i,
  input  wire logic [NUM_WIRED-1:0] lane_offset_bit_i,
  input  wire logic [NUM_WIRED-1:0] lane_scan_done_i,
  input  wire logic [5:0]           lane_voltage_a_i,
  input  wire logic [5:0]           lane_voltage_b_i,
  input  wire logic [7:0]           lane_phase_a_i,
  input  wire logic [7:0]           lane_phase_b_i,
  output logic      [3:0]           scan_mode_select_o,
  output logic      [3:0]           signal_loss_threshold_o,
  output logic                      signal_loss_detect_enable_o,
  output logic      [8:0]           equalizer_votes_o,
  output logic                      recovery_freeze_o,
  output logic                      irq_o
);

  // ---------------------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------------------
  if (ADR_W < 12) begin : g_adr_check
    $error("ADR_W must be at least 12 to reach every register");
  end

  if (NUM_WIRED != 2) begin : g_wired_check
    $error("the lane ports serve exactly two wired lanes");
  end

  if (IRQ_W != 2 * NUM_WIRED) begin : g_irq_check
    $error("IRQ_W must hold one done bit and one saturation bit per wired lane");
  end

  if (WIRED_LANE_A == WIRED_LANE_B) begin : g_lane_check
    $error("the two wired lanes must be distinct physical lanes");
  end

  // ---------------------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------------------
  function automatic logic [8:0] vote_decode(input logic [3:0] code);
    logic [8:0] votes;
    votes = VOTES_DEFAULT;
    if (code >= VOTE_CODE_MIN && code <= VOTE_CODE_MAX) begin
      votes = 9'((10'h1 << (code - 4'h1)) - 10'h1);
    end
    return votes;
  endfunction : vote_decode

  function automatic logic counts(input logic [3:0] mode, input logic nrm, input logic ofs);
    logic hit;
    hit = 1'b0;
    case (mode)
      MODE_COMPARE:       hit = nrm ^ ofs;
      MODE_COMPARE_ZEROS: hit = (nrm ^ ofs) && !nrm;
      MODE_COMPARE_ONES:  hit = (nrm ^ ofs) && nrm;
      MODE_COUNT_ONES:    hit = ofs;
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction : counts

  function automatic int wired_slot(input logic [3:0] lane);
    int slot;
    slot = -1;
    if (lane == WIRED_LANE_A) begin
      slot = 0;
    end else if (lane == WIRED_LANE_B) begin
      slot = 1;
    end
    return slot;
  endfunction : wired_slot

  // ---------------------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------------------
  logic [9:0] idx;
  logic       req;
  logic       wr_act;
  logic       rd_act;

  // A request is taken only while ack is low, so a strobe held into the ack cycle is not taken twice.
  assign idx    = wb_adr_i[11:2];
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_act = req && wb_we_i && wb_sel_i[0];
  assign rd_act = req && !wb_we_i;

  // ---------------------------------------------------------------------------
  // Software-written control registers.
  // ---------------------------------------------------------------------------
  logic                 err_clear_r;
  logic [3:0]           lane_select_r;
  logic [IRQ_W-1:0]     irq_mask_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_clear_r <= RST_ERR_CLEAR;
    end else if (wr_act && idx == IDX_ERR_CLEAR) begin
      err_clear_r <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      signal_loss_threshold_o <= RST_LOSS_THRESHOLD;
    end else if (wr_act && idx == IDX_LOSS_THRESHOLD) begin
      signal_loss_threshold_o <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      equalizer_votes_o <= vote_decode(RST_VOTE_SIZE);
    end else if (wr_act && idx == IDX_VOTE_SIZE) begin
      equalizer_votes_o <= vote_decode(wb_dat_i[3:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recovery_freeze_o <= RST_FREEZE;
    end else if (wr_act && idx == IDX_FREEZE) begin
      recovery_freeze_o <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_select_r <= RST_LANE_SELECT;
    end else if (wr_act && idx == IDX_LANE_SELECT) begin
      lane_select_r <= wb_dat_i[3:0];
    end
  end

  // Mode and loss-detect enable share one register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_mode_select_o          <= RST_SCAN_MODE;
      signal_loss_detect_enable_o <= 1'b0;
    end else if (wr_act && idx == IDX_SCAN_CONTROL) begin
      scan_mode_select_o          <= wb_dat_i[3:0];
      signal_loss_detect_enable_o <= wb_dat_i[POS_LOSS_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wr_act && idx == IDX_IRQ_MASK) begin
      irq_mask_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Raw vote code is kept for readback since the decoded count loses reserved codes.
  logic [3:0] vote_code_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vote_code_r <= RST_VOTE_SIZE;
    end else if (wr_act && idx == IDX_VOTE_SIZE) begin
      vote_code_r <= wb_dat_i[3:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Per-lane error counters, done flags, results and phase.
  // ---------------------------------------------------------------------------
  logic [15:0]          count_r [NUM_WIRED];
  logic [5:0]           voltage_r [NUM_WIRED];
  logic [7:0]           phase_r [NUM_WIRED];
  logic [NUM_WIRED-1:0] done_r;
  logic [NUM_WIRED-1:0] done_rise;
  logic [NUM_WIRED-1:0] sat_hit;
  logic [5:0]           volt_in [NUM_WIRED];
  logic [7:0]           phase_in [NUM_WIRED];

  assign volt_in[0]  = lane_voltage_a_i;
  assign volt_in[1]  = lane_voltage_b_i;
  assign phase_in[0] = lane_phase_a_i;
  assign phase_in[1] = lane_phase_b_i;

  for (genvar l = 0; l < NUM_WIRED; l++) begin : g_lane
    logic hit;
    assign hit          = lane_sample_valid_i[l] && !done_r[l]
                          && counts(scan_mode_select_o, lane_normal_bit_i[l], lane_offset_bit_i[l]);
    assign done_rise[l] = lane_scan_done_i[l] && !done_r[l];
    assign sat_hit[l]   = hit && !err_clear_r && count_r[l] == COUNT_MAX - 16'h1;

    // Counting saturates at the top so a long scan never wraps back to small values.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        count_r[l] <= '0;
      end else if (err_clear_r) begin
        count_r[l] <= '0;
      end else if (hit && count_r[l] != COUNT_MAX) begin
        count_r[l] <= count_r[l] + 16'h1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        done_r[l] <= 1'b0;
      end else begin
        done_r[l] <= lane_scan_done_i[l];
      end
    end

    // The voltage result is captured at the rise of scan done, only while bit 3 of the scan mode is set, so it stays put while read.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        voltage_r[l] <= '0;
      end else if (done_rise[l] && scan_mode_select_o[3]) begin
        voltage_r[l] <= volt_in[l];
      end
    end

    // Tracking stops while frozen so the gray-coded phase reads constant.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        phase_r[l] <= '0;
      end else if (!recovery_freeze_o) begin
        phase_r[l] <= phase_in[l];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Scan-complete vector mapped onto physical lanes.
  // ---------------------------------------------------------------------------
  logic [NUM_LANES-1:0] complete_vec;

  always_comb begin
    complete_vec               = '0;
    complete_vec[WIRED_LANE_A] = done_r[0];
    complete_vec[WIRED_LANE_B] = done_r[1];
  end

  // ---------------------------------------------------------------------------
  // Interrupt status: read clears, a new event wins over the clear.
  // ---------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_event;
  logic             irq_clear;

  assign irq_event = {sat_hit, done_rise};
  assign irq_clear = rd_act && idx == IDX_IRQ_STATUS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_clear ? '0 : irq_status_r) | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data mux.
  // ---------------------------------------------------------------------------
  logic [31:0] rd_data;
  int          slot;
  logic [3:0]  lane_off;

  assign lane_off = idx[3:0];

  always_comb begin
    rd_data = '0;
    slot    = -1;
    if (idx >= IDX_VOLTAGE_BASE && idx < IDX_VOLTAGE_BASE + 10'(NUM_LANES)) begin
      slot = wired_slot(lane_off);
      if (slot >= 0) begin
        rd_data[5:0] = voltage_r[slot[0]];
      end
    end else if (idx >= IDX_MISMATCH_BASE && idx < IDX_MISMATCH_BASE + 10'(NUM_LANES)) begin
      slot = wired_slot(lane_off);
      if (slot >= 0) begin
        rd_data[15:0] = count_r[slot[0]];
      end
    end else begin
      case (idx)
        IDX_ERR_CLEAR:      rd_data[0]    = err_clear_r;
        IDX_SCAN_COMPLETE:  rd_data[15:0] = complete_vec;
        IDX_LOSS_THRESHOLD: rd_data[3:0]  = signal_loss_threshold_o;
        IDX_VOTE_SIZE:      rd_data[3:0]  = vote_code_r;
        IDX_FREEZE:         rd_data[0]    = recovery_freeze_o;
        IDX_PHASE: begin
          slot = wired_slot(lane_select_r);
          if (slot >= 0) begin
            rd_data[7:0] = phase_r[slot[0]];
          end
        end
        IDX_LANE_SELECT:    rd_data[3:0]  = lane_select_r;
        IDX_SCAN_CONTROL: begin
          rd_data[3:0]            = scan_mode_select_o;
          rd_data[POS_LOSS_ENABLE] = signal_loss_detect_enable_o;
        end
        IDX_IRQ_STATUS:     rd_data[IRQ_W-1:0] = irq_status_r;
        IDX_IRQ_MASK:       rd_data[IRQ_W-1:0] = irq_mask_r;
        default:            rd_data = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Wishbone answer: one wait state, unmapped reads return zero.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else begin
      wb_dat_o <= rd_act ? rd_data : '0;
    end
  end

endmodule : serr_regs

`default_nettype wire
